//--- shared/csp_pkg.sv
// constants, fields and link states of the codec serial port
// assumes one 40 mhz processor clock and a codec that masters the link
package csp_pkg;
    localparam int          CSP_CLK_HZ      = 40_000_000;
    localparam int          CSP_BIT_RATE_HZ = 768_000;
    localparam int          CSP_FRAME_HZ    = 24_000;
    localparam int          CSP_WORD_BITS   = 16;
    localparam int          CSP_SLOTS       = 2;
    localparam int          CSP_FRAME_BITS  = CSP_BIT_RATE_HZ / CSP_FRAME_HZ;
    localparam int          CSP_CNT_W       = 5;
    localparam int          CSP_FIFO_DEPTH  = 8;
    localparam int          CSP_RX_W        = CSP_WORD_BITS + 1;
    localparam logic [4:0]  CSP_LAST_BIT    = 5'h1f;
    localparam logic [4:0]  CSP_WORD_END    = 5'h0f;
    // avalon map, byte addresses
    localparam int          CSP_AW          = 5;
    localparam logic [4:0]  CSP_OFS_CTRL    = 5'h00;
    localparam logic [4:0]  CSP_OFS_STAT    = 5'h04;
    localparam logic [4:0]  CSP_OFS_TXDATA  = 5'h08;
    localparam logic [4:0]  CSP_OFS_RXDATA  = 5'h0c;
    // control fields
    localparam int          CSP_CTRL_TXEN   = 0;
    localparam int          CSP_CTRL_RXEN   = 1;
    localparam int          CSP_CTRL_AFS_LO = 2;
    localparam logic [1:0]  CSP_AFS_LEAD1   = 2'h2;
    localparam logic [1:0]  CSP_AFS_ALIGN   = 2'h0;
    localparam logic [3:0]  CSP_CTRL_RST    = 4'h8;
    // status fields
    localparam int          CSP_ST_UNDER    = 0;
    localparam int          CSP_ST_OVER     = 1;
    localparam int          CSP_ST_TXFULL   = 2;
    localparam int          CSP_ST_RXAVAIL  = 3;
    localparam int          CSP_ST_TXBUSY   = 4;
    localparam int          CSP_ST_RXBUSY   = 5;
    // receive data word
    localparam int          CSP_RD_VALID    = 31;
    localparam int          CSP_RD_SLOT     = 16;
    // synchroniser lanes
    localparam int          CSP_PIN_N       = 5;
    localparam int          CSP_P_TCLK      = 0;
    localparam int          CSP_P_TFS       = 1;
    localparam int          CSP_P_RCLK      = 2;
    localparam int          CSP_P_RFS       = 3;
    localparam int          CSP_P_DIN       = 4;

    typedef enum logic [1:0] {
        CSP_IDLE,
        CSP_PEND,
        CSP_SHIFT
    } csp_link_e;
endpackage

//--- hw/csp_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes depth is a power of two; one clock domain
`timescale 1ns/1ps
module csp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = cnt_r != FULL_CNT;
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage has no reset; empty count hides stale words
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

//--- hw/csp_codec_port.sv
// codec-facing serial port: avalon registers, tx/rx shifters, fifos
// assumes the codec masters bit clocks and frame syncs on its pins
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module csp_codec_port (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [csp_pkg::CSP_AW-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       port1_tx_bit_clock,
    output logic                            port1_tx_bit_clock_o,
    output logic                            port1_tx_bit_clock_oe,
    input  wire logic                       port1_tx_frame_sync,
    output logic                            port1_tx_frame_sync_o,
    output logic                            port1_tx_frame_sync_oe,
    input  wire logic                       rx_bit_clock,
    input  wire logic                       rx_frame_sync,
    input  wire logic                       serial_data_in,
    output logic                            serial_data_out
);
    import csp_pkg::*;

    function automatic logic edge_up(input logic cur, input logic prev);
        edge_up = cur & ~prev;
    endfunction

    // clock and sync pins stay inputs for the codec port
    assign port1_tx_bit_clock_o   = 1'b0;
    assign port1_tx_bit_clock_oe  = 1'b0;
    assign port1_tx_frame_sync_o  = 1'b0;
    assign port1_tx_frame_sync_oe = 1'b0;

    // synchronisers; data lane delayed like its clock lane
    logic [CSP_PIN_N-1:0] s1_r;
    logic [CSP_PIN_N-1:0] s2_r;
    logic                 tclk_d_r;
    logic                 rclk_d_r;
    logic                 tx_rise;
    logic                 rx_fall;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_r     <= '0;
            s2_r     <= '0;
            tclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end else begin
            s1_r     <= {serial_data_in, rx_frame_sync, rx_bit_clock,
                         port1_tx_frame_sync, port1_tx_bit_clock};
            s2_r     <= s1_r;
            tclk_d_r <= s2_r[CSP_P_TCLK];
            rclk_d_r <= s2_r[CSP_P_RCLK];
        end
    end

    // phases of one processor clock or more keep every edge visible
    assign tx_rise = edge_up(s2_r[CSP_P_TCLK], tclk_d_r);
    assign rx_fall = edge_up(~s2_r[CSP_P_RCLK], ~rclk_d_r);

    // control and status
    logic [3:0]  ctrl_r;
    logic        under_r;
    logic        over_r;
    logic        tx_en;
    logic        rx_en;
    logic        lead1;
    csp_link_e   tx_state_r;
    csp_link_e   rx_state_r;
    assign tx_en = ctrl_r[CSP_CTRL_TXEN];
    assign rx_en = ctrl_r[CSP_CTRL_RXEN];
    assign lead1 = ctrl_r[CSP_CTRL_AFS_LO+:2] == CSP_AFS_LEAD1;

    // fifo wires
    logic                     txf_in_ready;
    logic                     txf_out_valid;
    logic                     txf_out_ready;
    logic [CSP_WORD_BITS-1:0] txf_out_data;
    logic                     rxf_in_valid;
    logic                     rxf_in_ready;
    logic [CSP_RX_W-1:0]      rxf_in_data;
    logic                     rxf_out_valid;
    logic                     rxf_out_ready;
    logic [CSP_RX_W-1:0]      rxf_out_data;

    // avalon slave: one wait cycle, more for a tx data write while the tx fifo is full
    logic req;
    logic ack_r;
    logic accept;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_tx;
    logic hit_rx;
    logic stall;

    assign req      = avs_read | avs_write;
    assign hit_ctrl = avs_address == CSP_OFS_CTRL;
    assign hit_stat = avs_address == CSP_OFS_STAT;
    assign hit_tx   = avs_address == CSP_OFS_TXDATA;
    assign hit_rx   = avs_address == CSP_OFS_RXDATA;
    assign stall    = avs_write & hit_tx & ~txf_in_ready;
    assign accept   = req & ack_r;
    assign avs_waitrequest = req & ~ack_r;
    assign rxf_out_ready   = accept & avs_read & hit_rx;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r & ~stall;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= '0;
            if (hit_ctrl) begin
                avs_readdata[3:0] <= ctrl_r;
            end else if (hit_stat) begin
                avs_readdata[CSP_ST_UNDER]   <= under_r;
                avs_readdata[CSP_ST_OVER]    <= over_r;
                avs_readdata[CSP_ST_TXFULL]  <= ~txf_in_ready;
                avs_readdata[CSP_ST_RXAVAIL] <= rxf_out_valid;
                avs_readdata[CSP_ST_TXBUSY]  <= tx_state_r != CSP_IDLE;
                avs_readdata[CSP_ST_RXBUSY]  <= rx_state_r != CSP_IDLE;
            end else if (hit_rx) begin
                avs_readdata[CSP_RD_VALID] <= rxf_out_valid;
                avs_readdata[CSP_RD_SLOT:0] <= rxf_out_data;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= CSP_CTRL_RST;
        end else if (accept && avs_write && hit_ctrl && avs_byteenable[0]) begin
            ctrl_r <= avs_writedata[3:0];
        end
    end

    // transmit engine
    csp_link_e                tx_state_nxt;
    logic [CSP_CNT_W-1:0]     tx_cnt_r;
    logic [CSP_WORD_BITS-1:0] tx_sh_r;
    logic                     tx_fs_prev_r;
    logic                     tx_armed_r;
    logic                     tx_fs_edge;
    logic                     tx_load_l;
    logic                     tx_load_rt;
    logic                     tx_load;
    logic [CSP_WORD_BITS-1:0] tx_word;

    assign tx_fs_edge = tx_rise & edge_up(s2_r[CSP_P_TFS], tx_fs_prev_r);
    assign tx_load    = tx_load_l | tx_load_rt;
    assign tx_word    = txf_out_valid ? txf_out_data : '0;
    assign txf_out_ready = tx_load;

    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_load_l    = 1'b0;
        tx_load_rt   = 1'b0;
        if (!tx_en) begin
            tx_state_nxt = CSP_IDLE;
        end else if (tx_rise) begin
            unique case (tx_state_r)
                CSP_IDLE: begin
                    if (tx_fs_edge && lead1) begin
                        tx_state_nxt = CSP_PEND;
                    end else if (tx_fs_edge) begin
                        tx_load_l    = 1'b1;
                        tx_state_nxt = CSP_SHIFT;
                    end
                end
                CSP_PEND: begin
                    tx_load_l    = 1'b1;
                    tx_state_nxt = CSP_SHIFT;
                end
                CSP_SHIFT: begin
                    if (tx_cnt_r == CSP_LAST_BIT) begin
                        if (tx_armed_r || (tx_fs_edge && !lead1)) begin
                            tx_load_l = 1'b1;
                        end else if (tx_fs_edge) begin
                            tx_state_nxt = CSP_PEND;
                        end else begin
                            tx_state_nxt = CSP_IDLE;
                        end
                    end else if (tx_cnt_r == CSP_WORD_END) begin
                        tx_load_rt = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_state_r   <= CSP_IDLE;
            tx_fs_prev_r <= 1'b0;
            tx_armed_r   <= 1'b0;
        end else begin
            tx_state_r <= tx_state_nxt;
            if (tx_rise) begin
                tx_fs_prev_r <= s2_r[CSP_P_TFS];
            end
            if (tx_load_l || tx_state_nxt != CSP_SHIFT) begin
                tx_armed_r <= 1'b0;
            end else if (tx_fs_edge && lead1) begin
                tx_armed_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_cnt_r        <= '0;
            tx_sh_r         <= '0;
            serial_data_out <= 1'b0;
        end else if (tx_load_l) begin
            tx_cnt_r        <= '0;
            serial_data_out <= tx_word[CSP_WORD_BITS-1];
            tx_sh_r         <= {tx_word[CSP_WORD_BITS-2:0], 1'b0};
        end else if (tx_rise && tx_state_r == CSP_SHIFT &&
                     tx_cnt_r != CSP_LAST_BIT) begin
            tx_cnt_r <= tx_cnt_r + 1'b1;
            if (tx_load_rt) begin
                serial_data_out <= tx_word[CSP_WORD_BITS-1];
                tx_sh_r         <= {tx_word[CSP_WORD_BITS-2:0], 1'b0};
            end else begin
                serial_data_out <= tx_sh_r[CSP_WORD_BITS-1];
                tx_sh_r         <= {tx_sh_r[CSP_WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // receive engine; a word that finds the fifo full is dropped
    logic [CSP_CNT_W-1:0]     rx_cnt_r;
    logic [CSP_WORD_BITS-2:0] rx_sh_r;
    logic                     rx_fs_prev_r;
    logic                     rx_fs_edge;
    logic                     rx_bit;
    logic                     rx_right;

    assign rx_fs_edge = rx_fall & edge_up(s2_r[CSP_P_RFS], rx_fs_prev_r);
    assign rx_bit     = rx_fall && rx_state_r == CSP_SHIFT;
    assign rx_right   = rx_cnt_r == CSP_LAST_BIT;
    assign rxf_in_valid = rx_bit && (rx_right || rx_cnt_r == CSP_WORD_END);
    assign rxf_in_data  = {rx_right, rx_sh_r, s2_r[CSP_P_DIN]};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_state_r   <= CSP_IDLE;
            rx_cnt_r     <= '0;
            rx_sh_r      <= '0;
            rx_fs_prev_r <= 1'b0;
        end else if (!rx_en) begin
            rx_state_r <= CSP_IDLE;
        end else if (rx_fall) begin
            rx_fs_prev_r <= s2_r[CSP_P_RFS];
            if (rx_state_r == CSP_SHIFT) begin
                rx_sh_r  <= {rx_sh_r[CSP_WORD_BITS-3:0], s2_r[CSP_P_DIN]};
                rx_cnt_r <= rx_cnt_r + 1'b1;
            end
            if (rx_fs_edge && (rx_state_r == CSP_IDLE || rx_right)) begin
                rx_state_r <= CSP_SHIFT;
                rx_cnt_r   <= '0;
            end else if (rx_right) begin
                rx_state_r <= CSP_IDLE;
            end
        end
    end

    // sticky errors, set wins over write-one-to-clear
    logic clr_stat;
    assign clr_stat = accept & avs_write & hit_stat & avs_byteenable[0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            under_r <= 1'b0;
            over_r  <= 1'b0;
        end else begin
            if (tx_load && !txf_out_valid) begin
                under_r <= 1'b1;
            end else if (clr_stat && avs_writedata[CSP_ST_UNDER]) begin
                under_r <= 1'b0;
            end
            if (rxf_in_valid && !rxf_in_ready) begin
                over_r <= 1'b1;
            end else if (clr_stat && avs_writedata[CSP_ST_OVER]) begin
                over_r <= 1'b0;
            end
        end
    end

    csp_fifo #(
        .WIDTH (CSP_WORD_BITS),
        .DEPTH (CSP_FIFO_DEPTH)
    ) u_tx_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (accept & avs_write & hit_tx),
        .in_ready  (txf_in_ready),
        .in_data   (avs_writedata[CSP_WORD_BITS-1:0]),
        .out_valid (txf_out_valid),
        .out_ready (txf_out_ready),
        .out_data  (txf_out_data)
    );

    csp_fifo #(
        .WIDTH (CSP_RX_W),
        .DEPTH (CSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (rxf_in_valid),
        .in_ready  (rxf_in_ready),
        .in_data   (rxf_in_data),
        .out_valid (rxf_out_valid),
        .out_ready (rxf_out_ready),
        .out_data  (rxf_out_data)
    );

    // checks
    logic       rx_seen_left_r;
    logic [5:0] tx_rises_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_seen_left_r <= 1'b0;
            tx_rises_r     <= '0;
        end else begin
            if (rxf_in_valid) begin
                rx_seen_left_r <= ~rx_right;
            end
            if (tx_load_l) begin
                tx_rises_r <= '0;
            end else if (tx_rise && tx_rises_r != 6'h3f) begin
                tx_rises_r <= tx_rises_r + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_pins_in;
        port1_tx_bit_clock_oe == 1'b0 && port1_tx_frame_sync_oe == 1'b0;
    endproperty
    a_pins_in: assert property (p_pins_in) else $error("clock pin driven");

    property p_sync_edge;
        $rose(port1_tx_bit_clock) |-> ##[1:3] tx_rise;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("rise missed");

    property p_dout_on_rise;
        $changed(serial_data_out) |-> $past(tx_rise);
    endproperty
    a_dout_on_rise: assert property (p_dout_on_rise) else $error("dout moved");

    property p_lead_one_b;
        tx_state_r == CSP_PEND && tx_en && !tx_rise |-> !tx_load_l;
    endproperty
    a_lead_one_b: assert property (p_lead_one_b) else $error("early bit");

    property p_start_needs_sync;
        $rose(tx_state_r == CSP_SHIFT) |->
            $past(tx_state_r) == CSP_PEND || $past(tx_fs_edge);
    endproperty
    a_start_needs_sync: assert property (p_start_needs_sync) else $error("no sync");

    property p_pend_sync;
        $rose(tx_state_r == CSP_PEND) |-> $past(tx_fs_edge) && $past(lead1);
    endproperty
    a_pend_sync: assert property (p_pend_sync) else $error("pend cause");

    property p_word_len;
        tx_load_rt |-> tx_rises_r == 6'(CSP_WORD_BITS - 1);
    endproperty
    a_word_len: assert property (p_word_len) else $error("word length");

    property p_rx_left_first;
        rxf_in_valid && rx_right |-> rx_seen_left_r;
    endproperty
    a_rx_left_first: assert property (p_rx_left_first) else $error("slot order");

    property p_rx_on_fall;
        $changed(rx_cnt_r) |-> $past(rx_fall);
    endproperty
    a_rx_on_fall: assert property (p_rx_on_fall) else $error("rx off fall");

    property p_rx_start;
        $rose(rx_state_r == CSP_SHIFT) |-> $past(rx_fs_edge);
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("rx no sync");

    c_tx_right: cover property (tx_load_rt);
    c_rx_right: cover property (rxf_in_valid && rx_right);
    c_under: cover property ($rose(under_r));
    c_over: cover property ($rose(over_r));
endmodule

//--- tb/csp_codec_model.sv
// behavioural audio codec: masters bit clock and frame sync of the link
// assumes the bench calls run_frame; the clock stands still between frames
`timescale 1ns/1ps
module csp_codec_model (
    output logic      bit_clock,
    output logic      frame_sync,
    output logic      data_to_dev,
    input  wire logic data_from_dev
);
    initial begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        data_to_dev = 1'b0;
    end

    // one idle lead bit so the first sync is a real rising edge
    task automatic run_frame(input logic sync, input logic lead,
                             input logic [31:0] words,
                             output logic [31:0] got);
        got = '0;
        #7;
        for (int k = 0; k < 36; k++) begin
            bit_clock = 1'b1;
            frame_sync = sync && (k == 1);
            if (k >= 2 && k <= 33) begin
                data_to_dev = words[33-k];
            end else begin
                data_to_dev = ~data_to_dev;
            end
            #100;
            bit_clock = 1'b0;
            #90;
            // sampled late: the device answers a few processor clocks in
            if (k >= 1 + lead && k <= 32 + lead) begin
                got[32 + lead - k] = data_from_dev;
            end
            #10;
        end
    endtask
endmodule

//--- tb/test_codec_serial_port_link.sv
// self-checking bench of the codec serial port with a codec model
// assumes the design and package compiled first; 40 mhz processor clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
end
module test_codec_serial_port_link;
    import csp_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        bclk;
    logic        fs;
    logic        din;
    logic        dout;
    logic        clk_oe;
    logic        fs_oe;
    int          failures = 0;
    int          n_compared = 0;
    int          seed = 50;
    logic        lead = 1'b1;
    logic [31:0] rd;
    logic [15:0] tw[$];
    logic [31:0] rq[$];

    always #12.5 clock = ~clock;

    csp_codec_port dut_u (
        .clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port1_tx_bit_clock(bclk), .port1_tx_bit_clock_o(),
        .port1_tx_bit_clock_oe(clk_oe), .port1_tx_frame_sync(fs),
        .port1_tx_frame_sync_o(), .port1_tx_frame_sync_oe(fs_oe),
        .rx_bit_clock(bclk), .rx_frame_sync(fs), .serial_data_in(din),
        .serial_data_out(dout)
    );

    csp_codec_model codec_u (
        .bit_clock(bclk), .frame_sync(fs), .data_to_dev(din),
        .data_from_dev(dout)
    );

    function automatic logic [31:0] rx_exp(input logic right,
                                           input logic [15:0] w);
        return {1'b1, 14'h0, right, w};
    endfunction

    // held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic put_tx(input int n);
        logic [15:0] w;
        repeat (n) begin
            w = $random(seed);
            tw.push_back(w);
            bus(1'b1, CSP_OFS_TXDATA, {16'h0, w}, rd);
        end
    endtask

    // an empty tx fifo sends zeros; a missing sync leaves dout still
    task automatic frames(input int n, input logic sync);
        logic [31:0] words;
        logic [31:0] exp;
        logic [31:0] got;
        repeat (n) begin
            words = $random(seed);
            exp = '0;
            if (sync && tw.size() >= 2) begin
                exp[31:16] = tw.pop_front();
                exp[15:0] = tw.pop_front();
            end
            codec_u.run_frame(sync, lead, words, got);
            `CHK("tx bits", exp, got)
            if (sync && rq.size() < 8) begin
                rq.push_back(rx_exp(1'b0, words[31:16]));
                rq.push_back(rx_exp(1'b1, words[15:0]));
            end
        end
    endtask

    task automatic drain_rx;
        while (rq.size() > 0) begin
            bus(1'b0, CSP_OFS_RXDATA, '0, rd);
            `CHK("rx word", rq.pop_front(), rd)
        end
        bus(1'b0, CSP_OFS_RXDATA, '0, rd);
        `CHK("rx empty", 1'b0, rd[CSP_RD_VALID])
    endtask

    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK("pin oe", 2'b00, {clk_oe, fs_oe})
        bus(1'b0, CSP_OFS_CTRL, '0, rd);
        `CHK("ctrl reset", 32'h8, rd)
        bus(1'b0, 5'h10, '0, rd);
        `CHK("unmapped", 32'h0, rd)
        put_tx(8);
        bus(1'b0, CSP_OFS_STAT, '0, rd);
        `CHK("tx full", 1'b1, rd[CSP_ST_TXFULL])
        bus(1'b1, CSP_OFS_CTRL, 32'hb, rd);
        frames(5, 1'b1);
        bus(1'b0, CSP_OFS_STAT, '0, rd);
        `CHK("under over", 2'b11, rd[1:0])
        frames(1, 1'b0);
        drain_rx();
        bus(1'b1, CSP_OFS_STAT, 32'h3, rd);
        bus(1'b0, CSP_OFS_STAT, '0, rd);
        `CHK("flags clear", 2'b00, rd[1:0])
        repeat (3) begin
            put_tx(2);
            frames(1, 1'b1);
            drain_rx();
        end
        // sync aligned with the first bit
        lead = 1'b0;
        bus(1'b1, CSP_OFS_CTRL, 32'h3, rd);
        put_tx(2);
        frames(1, 1'b1);
        drain_rx();
        end_sim();
    end
endmodule
